/* core/psw_defines.vh */
// constants for the processor sleep and wake controller
// assumes a classic Wishbone slave with 32-bit data and byte addresses
`ifndef PSW_DEFINES_VH
`define PSW_DEFINES_VH

// ==========================================================
// register map (byte addresses)
`define PSW_ADDR_CTRL        8'h00
`define PSW_ADDR_STATUS      8'h04

// ==========================================================
// control register fields
`define PSW_BIT_SLEEPONRET   1
`define PSW_BIT_DEEPSEL      2
`define PSW_BIT_PENDEVT      4
`define PSW_CTRL_RESET       32'h0000_0000

// ==========================================================
// status register fields
`define PSW_ST_ASLEEP        0
`define PSW_ST_DEEP          1
`define PSW_ST_EVENT         2
`define PSW_ST_CAUSE_LO      3

// ==========================================================
// sleep causes
`define PSW_CAUSE_NONE       2'h0
`define PSW_CAUSE_WAITINT    2'h1
`define PSW_CAUSE_WAITEVT    2'h2
`define PSW_CAUSE_EXIT       2'h3

`endif

/* core/psw_event_latch.v */
// one-bit event latch for wait-for-event
// assumes single-cycle pulses from the pipeline, synchronous reset
`timescale 1ns/1ps
module psw_event_latch (
    input  wire mclk,        // system clock
    input  wire sys_rst,     // sync reset, active high
    input  wire setEvent,    // send-event or pend event pulse
    input  wire consume,     // event wait falls through, clears
    output reg  eventFlag    // latch state
);
    // ==========================================================
    // latch; a set in the same cycle as a consume wins
    always @(posedge mclk) begin
        if (sys_rst) begin
            eventFlag <= 1'b0;
        end else if (setEvent) begin
            eventFlag <= 1'b1;
        end else if (consume) begin
            eventFlag <= 1'b0;
        end
    end
endmodule // psw_event_latch

/* core/psw_sleep_ctrl.v */
// processor sleep and wake controller, top level
// assumes pulses from the pipeline, and a level plus a pend pulse from the interrupt controller
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "psw_defines.vh"
module psw_sleep_ctrl (
    input  wire        mclk,            // system clock, 200 MHz
    input  wire        sys_rst,         // sync reset, active high
    input  wire [7:0]  wb_adr_i,        // wishbone byte address
    input  wire [31:0] wb_dat_i,        // wishbone write data
    input  wire [3:0]  wb_sel_i,        // wishbone byte selects
    input  wire        wb_we_i,         // wishbone write
    input  wire        wb_cyc_i,        // wishbone cycle
    input  wire        wb_stb_i,        // wishbone strobe
    output reg  [31:0] wb_dat_o,        // wishbone read data
    output reg         wb_ack_o,        // wishbone ack
    output wire        wb_err_o,        // wishbone error, tied low
    input  wire        waitIntInstr,    // wait_interrupt_instr retired, pulse
    input  wire        waitEventInstr,  // wait_event_instr retired, pulse
    input  wire        sendEventInstr,  // send_event_instr retired, pulse
    input  wire        lastHandlerRet,  // return from last handler, pulse
    input  wire        excEntryReady,   // exception able to preempt, level
    input  wire        newPendIrq,      // new interrupt pending, pulse
    input  wire        debugWake,       // debug wake request, pulse
    input  wire        priorityMaskBit, // priority_mask_bit
    input  wire        faultMaskBit,    // fault_mask_bit
    output reg         coreClkGate,     // high stops core clock
    output reg         sysClkGate,      // high stops system clock
    output reg         pllPowerDown,    // high powers down pll
    output reg         flashPowerDown,  // high powers down flash
    output wire        coreHalted,      // core holds execution
    output wire        handlerHold      // entry held off by mask
);
    // ==========================================================
    // state encoding
    localparam RUN   = 1'b0;
    localparam SLEEP = 1'b1;

    // ==========================================================
    // sleep state and control bits
    reg        state;
    reg        next_state;
    reg [1:0]  cause;
    reg [1:0]  next_cause;
    reg        deepLatched;
    reg        next_deepLatched;
    reg        deepLevel;
    reg        next_coreGate;
    reg        next_deepGate;
    reg        wakeNow;
    reg        sleepOnRet;
    reg        deepSel;
    reg        pendEvtEn;

    // ==========================================================
    // bus side words
    reg [31:0] ctrlWord;
    reg [31:0] statusWord;
    reg [31:0] next_rdData;

    // ==========================================================
    // decoded strobes
    wire       eventFlag;
    wire       waitEvtFallThru;
    wire       pendEvent;
    wire       entryWaitInt;
    wire       entryWaitEvt;
    wire       entryHandlerRet;
    wire       sleepReq;
    wire       wakeByException;
    wire       wakeByPend;
    wire       wakeByDebug;
    wire       hit;
    wire       mapped;
    wire       ctrlWrite;
    wire       regRead;

    // ==========================================================
    // wishbone slave: ack one cycle after the taking edge
    assign hit       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign mapped    = (wb_adr_i == `PSW_ADDR_CTRL) || (wb_adr_i == `PSW_ADDR_STATUS);
    assign ctrlWrite = hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PSW_ADDR_CTRL);
    assign regRead   = hit & ~wb_we_i & mapped;
    // unmapped offsets read zero and still ack, so no error path
    assign wb_err_o  = 1'b0;

    // ==========================================================
    // readback words
    always @* begin
        ctrlWord                      = `PSW_CTRL_RESET;
        ctrlWord[`PSW_BIT_SLEEPONRET] = sleepOnRet;
        ctrlWord[`PSW_BIT_DEEPSEL]    = deepSel;
        ctrlWord[`PSW_BIT_PENDEVT]    = pendEvtEn;
    end

    // the event latch is kept off the status word on purpose
    always @* begin
        statusWord                                      = 32'h0000_0000;
        statusWord[`PSW_ST_ASLEEP]                      = state;
        statusWord[`PSW_ST_DEEP]                        = deepLatched;
        statusWord[`PSW_ST_CAUSE_LO+1:`PSW_ST_CAUSE_LO] = cause;
    end

    always @* begin
        next_rdData = 32'h0000_0000;
        if (regRead) begin
            case (wb_adr_i)
                `PSW_ADDR_CTRL: begin
                    next_rdData = ctrlWord;
                end
                `PSW_ADDR_STATUS: begin
                    next_rdData = statusWord;
                end
                default: begin
                    next_rdData = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            sleepOnRet <= 1'b0;
            deepSel    <= 1'b0;
            pendEvtEn  <= 1'b0;
        end else begin
            wb_ack_o <= hit;
            // read data stands only in the ack cycle
            wb_dat_o <= next_rdData;
            if (ctrlWrite) begin
                sleepOnRet <= wb_dat_i[`PSW_BIT_SLEEPONRET];
                deepSel    <= wb_dat_i[`PSW_BIT_DEEPSEL];
                pendEvtEn  <= wb_dat_i[`PSW_BIT_PENDEVT];
            end
        end
    end

    // ==========================================================
    // event latch, reachable only from hardware
    assign pendEvent       = pendEvtEn & newPendIrq;
    assign waitEvtFallThru = (state == RUN) & waitEventInstr & eventFlag;

    psw_event_latch psw_event_latch_i (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .setEvent  (sendEventInstr | pendEvent),
        .consume   (waitEvtFallThru),
        .eventFlag (eventFlag)
    );

    // ==========================================================
    // sleep entry, one source per pipeline pulse
    assign entryWaitInt    = waitIntInstr & ~excEntryReady;
    assign entryWaitEvt    = waitEventInstr & ~eventFlag;
    assign entryHandlerRet = lastHandlerRet & sleepOnRet;
    assign sleepReq        = entryWaitInt | entryWaitEvt | entryHandlerRet;

    // ==========================================================
    // wake sources
    assign wakeByException = excEntryReady;
    assign wakeByPend      = pendEvent;
    // debug may wake from any cause; software must sleep again itself
    assign wakeByDebug     = debugWake;

    always @* begin
        case (cause)
            `PSW_CAUSE_WAITEVT: begin
                wakeNow = wakeByException | wakeByPend | wakeByDebug;
            end
            `PSW_CAUSE_WAITINT,
            `PSW_CAUSE_EXIT: begin
                // priority mask does not block the wake, only the entry
                wakeNow = wakeByException | wakeByDebug;
            end
            default: begin
                wakeNow = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // sleep state machine
    always @* begin
        next_state = state;
        next_cause = cause;
        case (state)
            RUN: begin
                // a later sleep request re-enters after a spurious wake, unless excEntryReady or the event latch makes it fall through
                if (sleepReq) begin
                    next_state = SLEEP;
                    if (entryWaitInt) begin
                        next_cause = `PSW_CAUSE_WAITINT;
                    end else if (entryWaitEvt) begin
                        next_cause = `PSW_CAUSE_WAITEVT;
                    end else begin
                        next_cause = `PSW_CAUSE_EXIT;
                    end
                end
            end
            SLEEP: begin
                // sleep pulses are ignored until the core is awake again
                if (wakeNow) begin
                    next_state = RUN;
                    next_cause = `PSW_CAUSE_NONE;
                end
            end
            default: begin
                next_state = RUN;
                next_cause = `PSW_CAUSE_NONE;
            end
        endcase
    end

    // ==========================================================
    // sleep level: sampled on entry so that a later write cannot
    // change the level of a sleep already under way
    always @* begin
        next_deepLatched = deepLatched;
        if (state == RUN && sleepReq) begin
            next_deepLatched = deepSel;
        end
        deepLevel     = (state == RUN) ? deepSel : deepLatched;
        next_coreGate = next_state;
        next_deepGate = next_state & deepLevel;
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            state       <= RUN;
            cause       <= `PSW_CAUSE_NONE;
            deepLatched <= 1'b0;
        end else begin
            state       <= next_state;
            cause       <= next_cause;
            deepLatched <= next_deepLatched;
        end
    end

    // ==========================================================
    // clock and power controls, registered so the gates never glitch
    always @(posedge mclk) begin
        if (sys_rst) begin
            coreClkGate    <= 1'b0;
            sysClkGate     <= 1'b0;
            pllPowerDown   <= 1'b0;
            flashPowerDown <= 1'b0;
        end else begin
            coreClkGate    <= next_coreGate;
            // light level leaves system clock, pll and flash running
            sysClkGate     <= next_deepGate;
            pllPowerDown   <= next_deepGate;
            flashPowerDown <= next_deepGate;
        end
    end

    // ==========================================================
    // core outputs
    assign coreHalted  = state;
    // the wake still happens; entry waits for the priority mask to clear
    assign handlerHold = excEntryReady & priorityMaskBit & ~faultMaskBit;
endmodule // psw_sleep_ctrl

/* sim/psw_checker.sv */
// assertions on the sleep controller ports
// assumes bind into psw_sleep_ctrl
`timescale 1ns/1ps
module psw_checker (
    input wire logic mclk,            // clock
    input wire logic sys_rst,         // reset
    input wire logic waitIntInstr,    // wait for interrupt
    input wire logic excEntryReady,   // exception
    input wire logic debugWake,       // debug
    input wire logic priorityMaskBit, // mask
    input wire logic faultMaskBit,    // mask
    input wire logic coreClkGate,     // gate
    input wire logic sysClkGate,      // gate
    input wire logic pllPowerDown,    // pll
    input wire logic flashPowerDown,  // flash
    input wire logic coreHalted,      // asleep
    input wire logic handlerHold      // held
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_waitint_sleeps: assert property (waitIntInstr && !coreHalted && !excEntryReady
        |=> coreHalted) else $error("interrupt wait did not sleep");
    a_waitint_skip: assert property (waitIntInstr && !coreHalted && excEntryReady
        |=> !coreHalted) else $error("interrupt wait slept while wake true");
    a_exc_wakes: assert property (coreHalted && excEntryReady
        |=> !coreHalted) else $error("exception did not wake");
    a_debug_wake: assert property (coreHalted && debugWake |=> !coreHalted)
        else $error("debug did not wake");
    a_core_gate: assert property (coreClkGate == coreHalted)
        else $error("core gate differs from sleep");
    a_deep_gates: assert property (sysClkGate |-> pllPowerDown && flashPowerDown)
        else $error("deep level incomplete");
    a_level_kept: assert property (coreHalted && $past(coreHalted) |-> $stable(sysClkGate))
        else $error("level changed in sleep");
    a_hold_mask: assert property (handlerHold ==
        (excEntryReady && priorityMaskBit && !faultMaskBit)) else $error("hold wrong");
endmodule // psw_checker
bind psw_sleep_ctrl psw_checker psw_checker_i(.mclk(mclk), .sys_rst(sys_rst),
    .waitIntInstr(waitIntInstr), .excEntryReady(excEntryReady), .debugWake(debugWake),
    .priorityMaskBit(priorityMaskBit), .faultMaskBit(faultMaskBit),
    .coreClkGate(coreClkGate), .sysClkGate(sysClkGate), .pllPowerDown(pllPowerDown),
    .flashPowerDown(flashPowerDown), .coreHalted(coreHalted), .handlerHold(handlerHold));

/* sim/psw_irq_model.sv */
// interrupt controller stand-in
// assumes requests change at the rising edge
`timescale 1ns/1ps
module psw_irq_model (
    input  wire logic mclk,                 // clock
    input  wire logic irqReq,               // request
    input  wire logic irqEn,                // enabled
    output logic      excEntryReady = 1'b0, // entry-worthy
    output logic      newPendIrq = 1'b0     // pend pulse
);
    logic seen = 1'b0;
    always @(posedge mclk) begin
        seen <= irqReq;
        // a pend is new only on a rising request, even if disabled
        newPendIrq <= irqReq & ~seen;
        excEntryReady <= irqReq & irqEn;
    end
endmodule // psw_irq_model

/* sim/psw_sleep_ctrl_tb.sv */
// bench for the sleep controller
// assumes psw_irq_model as exception source
`timescale 1ns/1ps
`include "psw_defines.vh"
module psw_sleep_ctrl_tb;
    logic        mclk = 0, sys_rst = 1, cs = 0, we = 0, ack, halted, hold, exc, pend, err;
    logic        cG, sG, pll, fla, rq = 0, en = 1, pm = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, rd, q;
    logic [4:0]  pl = 5'h00; // wait int, wait event, send event, return, debug
    int          n_mismatch = 0, checks_done = 0, cyc = 0;
    always #2.5 mclk = ~mclk;
    psw_irq_model psw_irq_model_i(.mclk(mclk), .irqReq(rq), .irqEn(en),
        .excEntryReady(exc), .newPendIrq(pend));
    psw_sleep_ctrl psw_sleep_ctrl_i(.mclk(mclk), .sys_rst(sys_rst), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cs), .wb_stb_i(cs),
        .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err), .waitIntInstr(pl[0]),
        .waitEventInstr(pl[1]), .sendEventInstr(pl[2]), .lastHandlerRet(pl[3]),
        .excEntryReady(exc), .newPendIrq(pend), .debugWake(pl[4]), .priorityMaskBit(pm),
        .faultMaskBit(1'b0), .coreClkGate(cG), .sysClkGate(sG), .pllPowerDown(pll),
        .flashPowerDown(fla), .coreHalted(halted), .handlerHold(hold));
    task results();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h", $time, got);
        end
    endtask
    task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge mclk) {adr, dat, we, cs} <= {a, d, w, 1'b1};
        do @(posedge mclk); while (ack !== 1'b1);
        rd = q;
        chk(err, 0);
        cs <= 0;
    endtask
    task pulse(input logic [4:0] v);
        @(posedge mclk) pl <= v;
        @(posedge mclk) pl <= 5'h00;
        #1;
    endtask
    // request, enable, priority mask
    task irq(input logic [2:0] s);
        @(posedge mclk) {rq, en, pm} <= s;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task s_wfi();
        #1 chk(halted, 0);
        wb(8'h08, 32'h0000_ffff, 1);
        wb(8'h08, 0, 0);
        chk(rd, 0);
        pulse(5'h01);
        chk({halted, cG, sG, pll}, 4'hc);
        irq(3'b110);
        chk(halted, 0);
        pulse(5'h01);
        chk(halted, 0);
        irq(3'b010);
    endtask
    task s_deep();
        wb(`PSW_ADDR_CTRL, 32'h0000_0004, 1);
        pulse(5'h01);
        chk({halted, cG, sG, pll, fla}, 5'h1f);
        irq(3'b111);
        chk({halted, hold}, 2'h1);
        chk({cG, sG, pll, fla}, 0);
        irq(3'b010);
    endtask
    task s_wfe();
        wb(`PSW_ADDR_CTRL, 0, 1);
        pulse(5'h04);
        wb(`PSW_ADDR_STATUS, 0, 0);
        chk(rd[`PSW_ST_EVENT], 0);
        pulse(5'h02);
        chk(halted, 0);
        pulse(5'h02);
        chk(halted, 1);
        irq(3'b100);
        chk(halted, 1);
        irq(3'b010);
        irq(3'b110);
        chk(halted, 0);
        irq(3'b010);
        pulse(5'h02);
        chk(halted, 1);
        wb(`PSW_ADDR_CTRL, 32'h0000_0010, 1);
        irq(3'b100);
        chk(halted, 0);
        irq(3'b010);
        pulse(5'h02);
        chk(halted, 0);
    endtask
    task s_exit();
        wb(`PSW_ADDR_CTRL, 32'h0000_0002, 1);
        pulse(5'h08);
        wb(`PSW_ADDR_STATUS, 0, 0);
        chk(rd, 32'h0000_0019);
        pulse(5'h10);
        chk(halted, 0);
        pulse(5'h01);
        chk(halted, 1);
        pulse(5'h04);
        @(posedge mclk) sys_rst <= 1;
        repeat (2) @(posedge mclk);
        sys_rst <= 0;
        #1 chk({halted, cG}, 0);
        pulse(5'h02);
        chk(halted, 1);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 0;
        s_wfi();
        s_deep();
        s_wfe();
        s_exit();
        results();
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            results();
        end
    end
endmodule // psw_sleep_ctrl_tb
